// ---- core/clk_gate_pkg.sv ----
`default_nettype none
package clk_gate_pkg;
	// Drive state handed to the analog output stages
	typedef enum logic [1:0] {
		DRV_RUN,      // Clock toggling
		DRV_LOW,      // Held low
		DRV_HIGH,     // True side driven high, current set by the iref6 outputs
		DRV_TRI       // Both sides undriven
	} drive_e;

	// Register offsets
	localparam logic [3:0] REG_OE     = 4'h0;
	localparam logic [3:0] REG_FREE   = 4'h1;
	localparam logic [3:0] REG_TRI    = 4'h2;
	localparam logic [3:0] REG_SE     = 4'h5;
	localparam logic [3:0] REG_STATUS = 4'h8;

	// Reset values
	localparam logic [7:0] OE_RST   = 8'h0F;
	localparam logic [7:0] FREE_RST = 8'h00;
	localparam logic [7:0] TRI_RST  = 8'h00;
	localparam logic [7:0] SE_RST   = 8'h9F;
	localparam logic [7:0] SE_MASK  = 8'hBF;  // Bit 6 reserved, reads 0

	// Field positions
	localparam int CPU_N       = 3;   // Number of CPU pairs
	localparam int SRC_BIT     = 3;   // Pair bit in OE and FREE registers
	localparam int TRI_CPD_LSB = 3;   // CPU power-down tristate bits [5:3]
	localparam int TRI_SSTOP   = 6;   // Pair stop tristate bit
	localparam int TRI_SPD     = 7;   // Pair power-down tristate bit
	localparam int SE_SEL      = 5;   // Shared pin select: 1 = 48 MHz
	localparam int SE_SH_EN    = 4;   // Shared pin enable

	// Input synchroniser lanes
	localparam int SY_PD   = 0;
	localparam int SY_CSTP = 1;
	localparam int SY_PSTP = 2;
	localparam int SY_CPUC = 3;
	localparam int SY_C66  = 4;
	localparam int SY_D48  = 5;
	localparam int SY_N    = 6;

	// Timing
	localparam int CLK_PS         = 20000;     // Core clock period
	localparam int PD_EXIT_US     = 1800;      // Power-down exit, longest
	localparam int PD_HIGH_US     = 300;       // Undriven pair to high, longest
	localparam int SH_LOW_PS      = 7490;      // Shared pin low, least
	localparam int PD_EXIT_CYC    = (PD_EXIT_US * 1000000) / CLK_PS;
	localparam int PD_HIGH_CYC    = (PD_HIGH_US * 1000000) / CLK_PS;
	localparam int SH_LOW_CYC_RAW = (SH_LOW_PS + CLK_PS - 1) / CLK_PS;
	localparam int SH_LOW_CYC     = (SH_LOW_CYC_RAW < 1) ? 1 : SH_LOW_CYC_RAW;
	localparam int PD_SAMPLES     = 2;         // Low samples before entry
	localparam int CNT_W          = 17;
	localparam logic [CNT_W-1:0] CNT_ONE = 17'h0_0001;
endpackage
`default_nettype wire

// ---- core/clk_output_gate.sv ----
// The plain strobed port and the register offsets were chosen for this implementation.
`default_nettype none
module clk_output_gate #(
	parameter int PD_EXIT_CYC = clk_gate_pkg::PD_EXIT_CYC,
	parameter int PD_HIGH_CYC = clk_gate_pkg::PD_HIGH_CYC
) (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 reset,
	// Power management pins, asynchronous, active low
	input  wire logic                 power_down_n,
	input  wire logic                 cpu_stop_n,
	input  wire logic                 pci_stop_n,
	// Internal clock references, sampled
	input  wire logic                 cpu_comp_clk,
	input  wire logic                 clk66_source,
	input  wire logic                 dot_clock_48m_source,
	// Register port
	input  wire logic [3:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output var  logic [7:0]           reg_rdata,
	// Drive states to the output stages
	output var  clk_gate_pkg::drive_e [2:0] cpu_drive,
	output var  logic [2:0]           cpu_iref6,
	output var  clk_gate_pkg::drive_e serial_ref_pair_drive,
	output var  logic                 serial_ref_pair_iref6,
	output var  clk_gate_pkg::drive_e [3:0] clk66_output_drive,
	output var  clk_gate_pkg::drive_e shared_drive,
	output var  logic                 video_48m_output_sel
);
	// Power-down sequencer states
	typedef enum logic [1:0] {PD_RUN, PD_DOWN, PD_EXIT} pd_e;
	// Shared pin switch states
	typedef enum logic [2:0] {
		SH_66, SH_LOW48, SH_WAIT48, SH_48, SH_LOW66, SH_WAIT66
	} sh_e;

	logic [clk_gate_pkg::SY_N-1:0] sync1;     // First synchroniser stage
	logic [clk_gate_pkg::SY_N-1:0] sync2;     // Second stage, safe to read
	logic [clk_gate_pkg::SY_N-1:0] sync_prev; // Previous sync2 for edges
	logic [7:0]  oe_reg;                      // Output enables
	logic [7:0]  free_reg;                    // Free-running bits
	logic [7:0]  tri_reg;                     // Tristate control byte two
	logic [7:0]  se_reg;                      // Single-ended control byte
	pd_e         pd_state;                    // Power-down phase
	logic [1:0]  pd_low_cnt;                  // Consecutive low samples
	logic [clk_gate_pkg::CNT_W-1:0] exit_cnt; // Exit delay countdown
	logic        se_hold;                     // Single-ended outputs held
	sh_e         sh_state;                    // Shared pin switch state
	logic [clk_gate_pkg::CNT_W-1:0] sh_cnt;   // Shared pin low time
	logic        cpuc_rise;                   // Complement rising edge
	logic        cpuc_fall;                   // Complement falling edge
	logic        cpuc_edge;                   // Any complement transition
	logic        c66_fall;                    // 66 MHz falling edge
	logic        c66_rise;                    // 66 MHz rising edge
	logic        d48_fall;                    // 48 MHz falling edge
	logic        d48_rise;                    // 48 MHz rising edge
	logic        pd_pin;                      // Power-down asserted
	logic        cstop;                       // CPU stop asserted
	logic        pstop;                       // PCI stop asserted
	logic        pd_hold;                     // Clocks held by power-down

	// Target drive state and current level for one pair
	function automatic logic [2:0] pair_target(
		input logic oe, input logic free, input logic stop_tri,
		input logic pd_tri, input logic stop, input pd_e ph);
		pair_target = {1'b0, clk_gate_pkg::DRV_RUN};
		if (!oe) begin
			pair_target = {1'b0, clk_gate_pkg::DRV_TRI};
		end else if (ph == PD_DOWN) begin
			pair_target = pd_tri ? {1'b0, clk_gate_pkg::DRV_TRI}
			                     : {1'b0, clk_gate_pkg::DRV_HIGH};
		end else if (ph == PD_EXIT) begin
			pair_target = {1'b0, clk_gate_pkg::DRV_HIGH};
		end else if (stop && !free) begin
			pair_target = stop_tri ? {1'b0, clk_gate_pkg::DRV_TRI}
			                       : {1'b1, clk_gate_pkg::DRV_HIGH};
		end
	endfunction

	// Two-flop synchronisers for pins and clock references
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			// Pins idle high, clock lanes idle low: no false edge
			sync1     <= 6'h07;
			sync2     <= 6'h07;
			sync_prev <= 6'h07;
		end else begin
			sync1     <= {dot_clock_48m_source, clk66_source, cpu_comp_clk,
			              pci_stop_n, cpu_stop_n, power_down_n};
			sync2     <= sync1;
			sync_prev <= sync2;
		end
	end

	// Edge strobes and asserted levels
	always_comb begin
		cpuc_rise = sync2[clk_gate_pkg::SY_CPUC]
		          & ~sync_prev[clk_gate_pkg::SY_CPUC];
		cpuc_fall = ~sync2[clk_gate_pkg::SY_CPUC]
		          & sync_prev[clk_gate_pkg::SY_CPUC];
		cpuc_edge = cpuc_rise | cpuc_fall;
		c66_rise  = sync2[clk_gate_pkg::SY_C66] & ~sync_prev[clk_gate_pkg::SY_C66];
		c66_fall  = ~sync2[clk_gate_pkg::SY_C66] & sync_prev[clk_gate_pkg::SY_C66];
		d48_rise  = sync2[clk_gate_pkg::SY_D48] & ~sync_prev[clk_gate_pkg::SY_D48];
		d48_fall  = ~sync2[clk_gate_pkg::SY_D48] & sync_prev[clk_gate_pkg::SY_D48];
		pd_pin    = ~sync2[clk_gate_pkg::SY_PD];
		cstop     = ~sync2[clk_gate_pkg::SY_CSTP];
		pstop     = ~sync2[clk_gate_pkg::SY_PSTP];
		pd_hold   = (pd_state != PD_RUN);
	end

	// Register writes
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			oe_reg   <= clk_gate_pkg::OE_RST;
			free_reg <= clk_gate_pkg::FREE_RST;
			tri_reg  <= clk_gate_pkg::TRI_RST;
			se_reg   <= clk_gate_pkg::SE_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				clk_gate_pkg::REG_OE:   oe_reg   <= reg_wdata;
				clk_gate_pkg::REG_FREE: free_reg <= reg_wdata;
				clk_gate_pkg::REG_TRI:  tri_reg  <= reg_wdata;
				clk_gate_pkg::REG_SE:
					se_reg <= reg_wdata & clk_gate_pkg::SE_MASK;
				default: begin
					// Unmapped or read-only: ignored
				end
			endcase
		end
	end

	// Register reads, data one cycle after the strobe
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				clk_gate_pkg::REG_OE:     reg_rdata <= oe_reg;
				clk_gate_pkg::REG_FREE:   reg_rdata <= free_reg;
				clk_gate_pkg::REG_TRI:    reg_rdata <= tri_reg;
				clk_gate_pkg::REG_SE:     reg_rdata <= se_reg;
				clk_gate_pkg::REG_STATUS:
					reg_rdata <= {3'h0, sh_state, pd_state};
				default:                  reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Power-down entry and exit sequencing
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pd_state   <= PD_RUN;
			pd_low_cnt <= 2'h0;
			exit_cnt   <= '0;
		end else begin
			case (pd_state)
				PD_RUN: begin
					// Count low samples on complement rising edges
					if (cpuc_rise) begin
						if (!pd_pin) begin
							pd_low_cnt <= 2'h0;
						end else if (pd_low_cnt == 2'(clk_gate_pkg::PD_SAMPLES - 1)) begin
							pd_low_cnt <= 2'h0;
							pd_state   <= PD_DOWN;
						end else begin
							pd_low_cnt <= pd_low_cnt + 2'h1;
						end
					end
				end
				PD_DOWN: begin
					if (!pd_pin) begin
						pd_state <= PD_EXIT;
						exit_cnt <= clk_gate_pkg::CNT_W'(PD_EXIT_CYC);
					end
				end
				PD_EXIT: begin
					// Controls are re-read when the delay runs out
					if (pd_pin) begin
						pd_state <= PD_DOWN;
					end else if (exit_cnt == clk_gate_pkg::CNT_ONE) begin
						pd_state <= PD_RUN;
						exit_cnt <= '0;
					end else begin
						exit_cnt <= exit_cnt - clk_gate_pkg::CNT_ONE;
					end
				end
				default: pd_state <= PD_RUN;
			endcase
		end
	end

	// CPU pairs: stop or hold at complement edges, leave tristate at once
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < clk_gate_pkg::CPU_N; i++) begin
				cpu_drive[i] <= clk_gate_pkg::DRV_RUN;
				cpu_iref6[i] <= 1'b0;
			end
		end else begin
			for (int i = 0; i < clk_gate_pkg::CPU_N; i++) begin
				logic [2:0] t;
				t = pair_target(oe_reg[i], free_reg[i], tri_reg[i],
				                tri_reg[clk_gate_pkg::TRI_CPD_LSB + i],
				                cstop, pd_state);
				// Power-down holds on the falling complement edge,
				// stop on any edge; disable and exit act directly
				if ((pd_state == PD_DOWN && cpuc_fall)
				    || (pd_state != PD_DOWN && cpuc_edge)
				    || !oe_reg[i] || pd_state == PD_EXIT
				    || (cpu_drive[i] == clk_gate_pkg::DRV_TRI
				        && t[1:0] != 2'(clk_gate_pkg::DRV_TRI))) begin
					cpu_drive[i] <= clk_gate_pkg::drive_e'(t[1:0]);
					cpu_iref6[i] <= t[2];
				end
			end
		end
	end

	// Serial reference pair, governed by PCI stop
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			serial_ref_pair_drive <= clk_gate_pkg::DRV_RUN;
			serial_ref_pair_iref6 <= 1'b0;
		end else begin
			logic [2:0] t;
			t = pair_target(oe_reg[clk_gate_pkg::SRC_BIT],
			                free_reg[clk_gate_pkg::SRC_BIT],
			                tri_reg[clk_gate_pkg::TRI_SSTOP],
			                tri_reg[clk_gate_pkg::TRI_SPD],
			                pstop, pd_state);
			if ((pd_state == PD_DOWN && cpuc_fall)
			    || (pd_state != PD_DOWN && cpuc_edge)
			    || !oe_reg[clk_gate_pkg::SRC_BIT]
			    || pd_state == PD_EXIT) begin
				serial_ref_pair_drive <= clk_gate_pkg::drive_e'(t[1:0]);
				serial_ref_pair_iref6 <= t[2];
			end
		end
	end

	// Single-ended hold, taken and released on a 66 MHz falling edge
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			se_hold <= 1'b0;
		end else if (c66_fall) begin
			se_hold <= pd_hold;
		end
	end

	// 66 MHz outputs: running or held low
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			clk66_output_drive <= {4{clk_gate_pkg::DRV_RUN}};
		end else begin
			for (int i = 0; i < 4; i++) begin
				clk66_output_drive[i] <= (se_hold || !se_reg[i])
				                       ? clk_gate_pkg::DRV_LOW : clk_gate_pkg::DRV_RUN;
			end
		end
	end

	// Shared pin source switch, low gap between sources
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sh_state <= SH_66;
			sh_cnt   <= '0;
		end else begin
			case (sh_state)
				SH_66: begin
					if (se_reg[clk_gate_pkg::SE_SEL] && c66_fall) begin
						sh_state <= SH_LOW48;
						sh_cnt   <= clk_gate_pkg::CNT_W'(clk_gate_pkg::SH_LOW_CYC);
					end
				end
				SH_LOW48: begin
					if (sh_cnt <= clk_gate_pkg::CNT_ONE) begin
						sh_state <= SH_WAIT48;
					end
					sh_cnt <= sh_cnt - clk_gate_pkg::CNT_ONE;
				end
				SH_WAIT48: begin
					if (d48_rise) begin
						sh_state <= SH_48;
					end
				end
				SH_48: begin
					if (!se_reg[clk_gate_pkg::SE_SEL] && d48_fall) begin
						sh_state <= SH_LOW66;
						sh_cnt   <= clk_gate_pkg::CNT_W'(clk_gate_pkg::SH_LOW_CYC);
					end
				end
				SH_LOW66: begin
					if (sh_cnt <= clk_gate_pkg::CNT_ONE) begin
						sh_state <= SH_WAIT66;
					end
					sh_cnt <= sh_cnt - clk_gate_pkg::CNT_ONE;
				end
				SH_WAIT66: begin
					if (c66_rise) begin
						sh_state <= SH_66;
					end
				end
				default: sh_state <= SH_66;
			endcase
		end
	end

	// Shared pin drive and source select
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			shared_drive         <= clk_gate_pkg::DRV_RUN;
			video_48m_output_sel <= 1'b0;
		end else begin
			video_48m_output_sel <= (sh_state == SH_48);
			if (se_hold || !se_reg[clk_gate_pkg::SE_SH_EN]
			    || (sh_state != SH_66 && sh_state != SH_48)) begin
				shared_drive <= clk_gate_pkg::DRV_LOW;
			end else begin
				shared_drive <= clk_gate_pkg::DRV_RUN;
			end
		end
	end

	// Checks
	logic [clk_gate_pkg::CNT_W-1:0] exit_age;  // Cycles since exit began
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			exit_age <= '0;
		end else if (pd_state == PD_EXIT) begin
			exit_age <= exit_age + clk_gate_pkg::CNT_ONE;
		end else begin
			exit_age <= '0;
		end
	end

	AST_DISABLED_TRI: assert property (@(posedge core_clk) disable iff (reset)
		!oe_reg[0] |=> cpu_drive[0] == clk_gate_pkg::DRV_TRI)
		else $error("disabled pair not tristated");
	AST_PD_ENTRY_TWO: assert property (@(posedge core_clk) disable iff (reset)
		$rose(pd_state == PD_DOWN) |-> pd_pin && $past(pd_state) == PD_RUN)
		else $error("power-down entered without samples");
	AST_PD_HIGH: assert property (@(posedge core_clk) disable iff (reset)
		pd_state == PD_DOWN && cpuc_fall && oe_reg[0]
		&& !tri_reg[clk_gate_pkg::TRI_CPD_LSB] && pd_pin
		|=> cpu_drive[0] == clk_gate_pkg::DRV_HIGH && !cpu_iref6[0])
		else $error("pair not driven high in power-down");
	AST_EXIT_HIGH: assert property (@(posedge core_clk) disable iff (reset)
		$rose(pd_state == PD_EXIT) && oe_reg[1]
		|=> cpu_drive[1] == clk_gate_pkg::DRV_HIGH)
		else $error("pair not driven high on exit");
	AST_EXIT_LEN: assert property (@(posedge core_clk) disable iff (reset)
		pd_state == PD_EXIT |-> exit_age < clk_gate_pkg::CNT_W'(PD_EXIT_CYC))
		else $error("exit delay too long");
	AST_FREE_RUN: assert property (@(posedge core_clk) disable iff (reset)
		pd_state == PD_RUN && free_reg[2] && oe_reg[2] && cpuc_edge
		|=> cpu_drive[2] == clk_gate_pkg::DRV_RUN)
		else $error("free-running pair stopped");
	AST_STOP_IREF6: assert property (@(posedge core_clk) disable iff (reset)
		pd_state == PD_RUN && cstop && oe_reg[0] && !free_reg[0]
		&& !tri_reg[0] && cpuc_edge
		|=> cpu_drive[0] == clk_gate_pkg::DRV_HIGH && cpu_iref6[0])
		else $error("stopped pair not at six times current");
	AST_NEVER_TRI: assert property (@(posedge core_clk) disable iff (reset)
		oe_reg[0] && !tri_reg[0] && !tri_reg[clk_gate_pkg::TRI_CPD_LSB]
		&& $past(oe_reg[0]) && !$past(tri_reg[0])
		&& !$past(tri_reg[clk_gate_pkg::TRI_CPD_LSB])
		|-> cpu_drive[0] != clk_gate_pkg::DRV_TRI)
		else $error("pair tristated with bits clear");
	AST_SHARED_GAP: assert property (@(posedge core_clk) disable iff (reset)
		sh_state == SH_LOW48 |=> shared_drive == clk_gate_pkg::DRV_LOW)
		else $error("shared pin not low during switch");
	AST_SE_LOW: assert property (@(posedge core_clk) disable iff (reset)
		se_hold |=> clk66_output_drive[0] == clk_gate_pkg::DRV_LOW)
		else $error("single-ended output not held low");

	COV_PD_CYCLE: cover property (@(posedge core_clk) disable iff (reset)
		pd_state == PD_EXIT ##1 pd_state == PD_RUN);
	COV_STOP_TRI: cover property (@(posedge core_clk) disable iff (reset)
		cpu_drive[0] == clk_gate_pkg::DRV_TRI && cstop);
	COV_SWITCH48: cover property (@(posedge core_clk) disable iff (reset)
		sh_state == SH_WAIT48 ##1 sh_state == SH_48);
endmodule
`default_nettype wire

// ---- sim/pm_partner.sv ----
`default_nettype none
// Platform power management driving the active-low control pins
module pm_partner (
	// Clocking
	input  wire logic core_clk,
	input  wire logic cpu_comp_clk,
	// Requests from the bench
	input  wire logic want_pd,
	input  wire logic want_cstop,
	input  wire logic want_pstop,
	input  wire logic glitch,
	// Pins, active low
	output var  logic power_down_n,
	output var  logic cpu_stop_n,
	output var  logic pci_stop_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       comp_q; // Previous complement level
	logic [1:0] rises;  // Complement rises seen while held low
	// Pins start deasserted
	initial begin
		power_down_n = 1'b1;
		cpu_stop_n = 1'b1;
		pci_stop_n = 1'b1;
		rises = 2'h0;
	end
	// Power-down stays low for three complement rises unless told to glitch
	always @(posedge core_clk) begin
		comp_q <= cpu_comp_clk;
		cpu_stop_n <= !want_cstop;
		pci_stop_n <= !want_pstop;
		if (power_down_n) begin
			rises <= 2'h0;
			power_down_n <= !want_pd;
		end else if (glitch || (!want_pd && rises == 2'h3)) begin
			power_down_n <= 1'b1;
		end else if (cpu_comp_clk && !comp_q && rises != 2'h3) begin
			rises <= rises + 2'h1;
		end
	end
endmodule
`default_nettype wire

// ---- sim/clock_output_stop_powerdown_ctrl_bench.sv ----
`default_nettype none
`define CHK(a, b) begin \
	check_count++; \
	if ((a) !== (b)) begin \
		error_cnt++; \
		$display("CHECK FAILED %0t got %h exp %h", $time, a, b); \
	end \
end
// Bench with a table model of the output drive states
module clock_output_stop_powerdown_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// Clock, reset and pins
	logic                         core_clk, reset;
	logic                         power_down_n, cpu_stop_n, pci_stop_n;
	logic                         cpu_comp_clk, clk66_source;
	logic                         dot_clock_48m_source;
	// Register port
	logic [3:0]                   reg_addr;
	logic [7:0]                   reg_wdata, reg_rdata;
	logic                         reg_wr, reg_rd;
	// Drive states
	clk_gate_pkg::drive_e [2:0]   cpu_drive;
	clk_gate_pkg::drive_e [3:0]   clk66_output_drive;
	clk_gate_pkg::drive_e         serial_ref_pair_drive, shared_drive;
	logic [2:0]                   cpu_iref6;
	logic                         serial_ref_pair_iref6, video_48m_output_sel;
	// Partner requests and bench state
	logic                         want_pd, want_cstop, want_pstop, glitch;
	logic                         saw_low;
	int                           error_cnt, check_count, cycles, seed, div;
	int                           mreg [16];

	clk_output_gate #(.PD_EXIT_CYC(20)) dut (.core_clk(core_clk),
		.reset(reset), .power_down_n(power_down_n), .cpu_stop_n(cpu_stop_n),
		.pci_stop_n(pci_stop_n), .cpu_comp_clk(cpu_comp_clk),
		.clk66_source(clk66_source),
		.dot_clock_48m_source(dot_clock_48m_source), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cpu_drive(cpu_drive), .cpu_iref6(cpu_iref6),
		.serial_ref_pair_drive(serial_ref_pair_drive),
		.serial_ref_pair_iref6(serial_ref_pair_iref6),
		.clk66_output_drive(clk66_output_drive), .shared_drive(shared_drive),
		.video_48m_output_sel(video_48m_output_sel));

	pm_partner pm (.core_clk(core_clk), .cpu_comp_clk(cpu_comp_clk),
		.want_pd(want_pd), .want_cstop(want_cstop), .want_pstop(want_pstop),
		.glitch(glitch), .power_down_n(power_down_n), .cpu_stop_n(cpu_stop_n),
		.pci_stop_n(pci_stop_n));

	// Core clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Slow reference clocks, a shared-pin low monitor and the hang limit
	always @(posedge core_clk) begin
		div <= div + 1;
		cpu_comp_clk <= 1'((div / 5) % 2);
		clk66_source <= 1'((div / 2) % 2);
		dot_clock_48m_source <= 1'((div / 3) % 2);
		if (shared_drive === clk_gate_pkg::DRV_LOW) saw_low <= 1'b1;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	// Expected drive of pair i (3 is the serial pair): 0 run, 2 high, 3 off
	function automatic logic [1:0] exp_drv(input int i, input logic pdn,
		input logic stn, input logic ex);
		logic oe, fr, st, pt;
		oe = mreg[0][i];
		fr = mreg[1][i];
		st = mreg[2][i == 3 ? clk_gate_pkg::TRI_SSTOP : i];
		pt = mreg[2][i == 3 ? clk_gate_pkg::TRI_SPD : i + 3];
		if (!oe) return 2'h3;
		if (!pdn) return pt ? 2'h3 : 2'h2;
		if (ex) return 2'h2;
		if (!stn && !fr) return st ? 2'h3 : 2'h2;
		return 2'h0;
	endfunction

	// Compare every pair with the model, and in power-down check the single-ended outputs and shared pin are low
	task automatic chk_pairs(input logic ex);
		logic [1:0] e;
		#1;
		for (int i = 0; i < 4; i++) begin
			e = exp_drv(i, power_down_n, i == 3 ? pci_stop_n : cpu_stop_n, ex);
			if (i < 3) begin
				`CHK(cpu_drive[i], e)
				if (e == 2'h2) `CHK(cpu_iref6[i], power_down_n && !ex)
			end else begin
				`CHK(serial_ref_pair_drive, e)
				if (e == 2'h2) `CHK(serial_ref_pair_iref6, power_down_n && !ex)
			end
			if (!power_down_n) `CHK(clk66_output_drive[i], clk_gate_pkg::DRV_LOW)
		end
		if (!power_down_n) `CHK(shared_drive, clk_gate_pkg::DRV_LOW)
	endtask

	// Register write, mirrored into the model
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		if (a < 4'h3) mreg[a] = d;
		if (a == 4'h5) mreg[5] = d & clk_gate_pkg::SE_MASK;
	endtask

	// Register read, data taken in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask

	// Closing report
	task automatic wrap_up();
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		seed = 32'hf2a3;
		reset = 1'b1;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{want_pd, want_cstop, want_pstop, glitch, saw_low} = '0;
		{cpu_comp_clk, clk66_source, dot_clock_48m_source} = '0;
		mreg = '{default: 0};
		mreg[0] = clk_gate_pkg::OE_RST;
		mreg[5] = clk_gate_pkg::SE_RST;
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		chk_pairs(1'b0);
		for (int a = 0; a < 16; a++) rd(4'(a), 8'(mreg[a]));
		wr(4'h8, 8'hFF);
		wr(4'hC, 8'h5A);
		rd(4'h8, 8'h00);
		rd(4'hC, 8'h00);
		// Random settings and pin levels against the table
		for (int k = 0; k < 40; k++) begin
			for (int a = 0; a < 3; a++) wr(4'(a), 8'($random(seed)));
			want_pd <= (($random(seed) & 3) == 0);
			want_cstop <= 1'($random(seed));
			want_pstop <= 1'($random(seed));
			repeat (60) @(posedge core_clk);
			chk_pairs(1'b0);
			rd(4'h8, {7'h00, !power_down_n});
			rd(4'h2, 8'(mreg[2]));
		end
		// Exit delay, with a stop release and a bit change inside it
		wr(4'h2, 8'h00);
		want_cstop <= 1'b1;
		want_pd <= 1'b1;
		repeat (60) @(posedge core_clk);
		want_pd <= 1'b0;
		repeat (6) @(posedge core_clk);
		chk_pairs(1'b1);
		rd(4'h8, 8'h02);
		want_cstop <= 1'b0;
		wr(4'h2, 8'hFF);
		repeat (30) @(posedge core_clk);
		chk_pairs(1'b0);
		// Shared pin switch to 48 MHz
		saw_low = 1'b0;
		wr(4'h5, 8'hBF);
		repeat (40) @(posedge core_clk);
		#1;
		`CHK(saw_low, 1'b1)
		`CHK(video_48m_output_sel, 1'b1)
		`CHK(shared_drive, clk_gate_pkg::DRV_RUN)
		rd(4'h8, 8'h0C);
		rd(4'h5, 8'hBF);
		// Disabled single-ended output 3 and shared pin sit low
		wr(4'h5, 8'h80);
		repeat (4) @(posedge core_clk);
		#1;
		`CHK(clk66_output_drive[3], clk_gate_pkg::DRV_LOW)
		`CHK(shared_drive, clk_gate_pkg::DRV_LOW)
		wr(4'h5, clk_gate_pkg::SE_RST);
		repeat (40) @(posedge core_clk);
		#1;
		`CHK(video_48m_output_sel, 1'b0)
		// One-cycle power-down glitch must be ignored
		@(posedge core_clk);
		want_pd <= 1'b1;
		glitch <= 1'b1;
		@(posedge core_clk);
		want_pd <= 1'b0;
		repeat (2) @(posedge core_clk);
		glitch <= 1'b0;
		repeat (30) @(posedge core_clk);
		rd(4'h8, 8'h00);
		chk_pairs(1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire
